// File: design/smcm_defines.svh
// Constants for the static memory chip-select mode logic.
// Assumes inclusion by bare name from design files.
`ifndef SMCM_DEFINES_SVH
`define SMCM_DEFINES_SVH

// ----------------------------------------------------------------
// Mode word field positions
// ----------------------------------------------------------------
`define SMCM_DF_CYC_MSB      19
`define SMCM_DF_CYC_LSB      16
`define SMCM_DF_OPT_BIT      20
`define SMCM_BUS_WIDTH_BIT   12
`define SMCM_BYTE_KIND_BIT   8
`define SMCM_WAIT_MSB        5
`define SMCM_WAIT_LSB        4
`define SMCM_WR_CTRL_BIT     1
`define SMCM_MODE_RESET      32'h0000_0000

// ----------------------------------------------------------------
// Counts and encodings
// ----------------------------------------------------------------
`define SMCM_CNT_W           6
`define SMCM_DF_W            4
`define SMCM_WAIT_OFF        2'h0
`define SMCM_WAIT_FROZEN     2'h2
`define SMCM_WAIT_READY      2'h3
`define SMCM_TURNAROUND      5'h01

`endif

// File: design/smcm_pkg.sv
// Types for the static memory chip-select mode logic.
// Assumes the defines header is available on the include path.
package smcm_pkg;

   typedef struct packed {
      logic [5:0] setup;
      logic [5:0] pulse;
      logic [5:0] hold;
   } smcm_timing_t;

   typedef struct packed {
      logic       cs_n;
      logic       rd_n;
      logic       wr_n;
      logic       bs_lo_n;
      logic       bs_hi_n;
      logic       bw_lo_n;
      logic       bw_hi_n;
   } smcm_strobes_t;

   typedef enum logic [2:0] {
      SMCM_IDLE,
      SMCM_SETUP,
      SMCM_PULSE,
      SMCM_READY_WAIT,
      SMCM_HOLD,
      SMCM_FLOAT
   } smcm_state_t;

endpackage : smcm_pkg

// File: design/smcm_wait_sync.sv
// Two-stage synchroniser for the external wait input.
// Assumes a single clock domain; reset value is released (high).
`timescale 1ns/1ps
`default_nettype none

module smcm_wait_sync (
   input  wire logic clk_sys_i,
   input  wire logic sys_rst_i,
   input  wire logic async_n_i,
   output logic      sync_n_o
);
   logic meta_reg;
   logic sync_reg;

   always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         meta_reg <= 1'b1;
         sync_reg <= 1'b1;
      end else begin
         meta_reg <= async_n_i;
         sync_reg <= meta_reg;
      end
   end

   assign sync_n_o = sync_reg;
endmodule // smcm_wait_sync

`default_nettype wire

// File: design/smcm_float_timer.sv
// Data-float down counter with the extra turnaround cycle.
// Assumes load is a one-cycle pulse at the end of a read.
`timescale 1ns/1ps
`default_nettype none
`include "smcm_defines.svh"

module smcm_float_timer (
   input  wire logic                   clk_sys_i,
   input  wire logic                   sys_rst_i,
   input  wire logic                   load_i,
   input  wire logic [`SMCM_DF_W-1:0]  cycles_i,
   input  wire logic                   consume_i,
   output logic                        busy_o,
   output logic [4:0]                  left_o
);
   logic [4:0] cnt_reg;
   logic [4:0] cnt_next;
   wire  [4:0] load_val = {1'b0, cycles_i} + `SMCM_TURNAROUND;

   assign cnt_next = load_i ? load_val :
                     (consume_i && cnt_reg != 5'h00) ? cnt_reg - 5'h01 : cnt_reg;

   always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
      if (sys_rst_i) cnt_reg <= 5'h00;
      else           cnt_reg <= cnt_next;
   end

   assign busy_o = (cnt_reg != 5'h00);
   assign left_o = cnt_reg;
endmodule // smcm_float_timer

`default_nettype wire

// File: design/smcm_chip_select.sv
// Per-chip-select access sequencer: bus width, byte strobes,
// data-float turnaround and external wait handling.
// Assumes inputs synchronous to clk_sys_i except ext_wait_n_i.
//
// Summary of operation
// - No optimization: full float before next access
// - Optimization: float overlaps next setup phase
// - Float count is bits 19:16, 0..15
// - One extra turnaround cycle after float
// - Bus blocked float plus one after read
// - Bit 12: 0 is 8-bit, 1 16-bit
// - Byte kind only honoured on 16-bit bus
// - Kind 0: strobe plus a byte select for each selected lane
// - Kind 1: per-byte write strobes, plain read
// - Wait sampled only during strobe pulse
// - Wait mode 0 ignores wait input
// - Mode 2 freezes cycle while wait low
// - Mode 3 extends pulse end until ready
// - Write control 0: chip select times write
`timescale 1ns/1ps
`default_nettype none
`include "smcm_defines.svh"

module smcm_chip_select
   import smcm_pkg::*;
(
   input  wire logic          clk_sys_i,
   input  wire logic          sys_rst_i,
   input  wire logic [31:0]   mode_i,
   input  wire smcm_timing_t  rd_tim_i,
   input  wire smcm_timing_t  wr_tim_i,
   input  wire logic          req_i,
   input  wire logic          req_write_i,
   input  wire logic [1:0]    req_bytes_i,
   input  wire logic          ext_wait_n_i,
   output logic               req_ready_o,
   output logic               done_o,
   output logic               bus_blocked_o,
   output logic               wide_bus_o,
   output smcm_strobes_t      strobes_o
);
   // ----------------------------------------------------------------
   // Mode decode
   // ----------------------------------------------------------------
   wire [3:0] df_cycles = mode_i[`SMCM_DF_CYC_MSB:`SMCM_DF_CYC_LSB];
   wire       df_opt    = mode_i[`SMCM_DF_OPT_BIT];
   wire       wide      = mode_i[`SMCM_BUS_WIDTH_BIT];
   wire       byte_kind = wide & mode_i[`SMCM_BYTE_KIND_BIT];
   wire [1:0] wait_mode = mode_i[`SMCM_WAIT_MSB:`SMCM_WAIT_LSB];
   wire       wr_by_cs  = ~mode_i[`SMCM_WR_CTRL_BIT];

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   smcm_state_t  state_reg;
   smcm_state_t  state_next;
   logic [5:0]   cnt_reg;
   logic [5:0]   cnt_next;
   logic         wr_reg;
   logic [1:0]   bytes_reg;
   logic         done_reg;
   smcm_strobes_t strb_reg;
   smcm_strobes_t strb_next;
   logic         wait_n_s;
   logic         df_busy;
   logic [4:0]   df_left;

   smcm_wait_sync u_sync (
      .clk_sys_i (clk_sys_i),
      .sys_rst_i (sys_rst_i),
      .async_n_i (ext_wait_n_i),
      .sync_n_o  (wait_n_s)
   );

   smcm_timing_t tim;
   assign tim = wr_reg ? wr_tim_i : rd_tim_i;
   smcm_timing_t req_tim;
   assign req_tim = req_write_i ? wr_tim_i : rd_tim_i;

   wire read_end   = (state_reg == SMCM_HOLD) && (cnt_reg == 6'h00) && !wr_reg;
   wire in_float   = (state_reg == SMCM_FLOAT);

   // Float counter runs down whenever it is pending; setup phase counts too
   smcm_float_timer u_float (
      .clk_sys_i (clk_sys_i),
      .sys_rst_i (sys_rst_i),
      .load_i    (read_end),
      .cycles_i  (df_cycles),
      .consume_i (1'b1),
      .busy_o    (df_busy),
      .left_o    (df_left)
   );

   // Optimized start allowed if remaining float fits inside next setup
   wire fits_setup = ({1'b0, df_left} <= req_tim.setup);
   wire may_start  = !df_busy || (df_opt && fits_setup);

   // Wait handling only inside the pulse phase
   wire in_pulse    = (state_reg == SMCM_PULSE);
   wire freeze      = in_pulse && (wait_mode == `SMCM_WAIT_FROZEN)
                      && !wait_n_s;
   wire ready_mode  = (wait_mode == `SMCM_WAIT_READY);
   // Mode 0 and reserved mode 1 leave the wait input unused
   wire wait_used   = (wait_mode == `SMCM_WAIT_FROZEN) || ready_mode;

   assign req_ready_o   = (state_reg == SMCM_IDLE) && may_start;
   assign bus_blocked_o = df_busy;
   assign wide_bus_o    = wide;
   assign done_o        = done_reg;
   assign strobes_o     = strb_reg;

   // ----------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------
   always_comb begin
      state_next = state_reg;
      cnt_next   = cnt_reg;
      case (state_reg)
         SMCM_IDLE: begin
            if (req_i && may_start) begin
               state_next = SMCM_SETUP;
               cnt_next   = req_tim.setup;
            end
         end
         SMCM_SETUP: begin
            if (cnt_reg == 6'h00) begin
               state_next = SMCM_PULSE;
               cnt_next   = tim.pulse;
            end else begin
               cnt_next = cnt_reg - 6'h01;
            end
         end
         SMCM_PULSE: begin
            if (wait_used && freeze) begin
               cnt_next = cnt_reg;
            end else if (cnt_reg != 6'h00) begin
               cnt_next = cnt_reg - 6'h01;
            end else if (wait_used && ready_mode && !wait_n_s) begin
               state_next = SMCM_READY_WAIT;
            end else begin
               state_next = SMCM_HOLD;
               cnt_next   = tim.hold;
            end
         end
         SMCM_READY_WAIT: begin
            if (wait_n_s) begin
               state_next = SMCM_HOLD;
               cnt_next   = tim.hold;
            end
         end
         SMCM_HOLD: begin
            if (cnt_reg != 6'h00) begin
               cnt_next = cnt_reg - 6'h01;
            end else if (!wr_reg) begin
               state_next = SMCM_FLOAT;
            end else begin
               state_next = SMCM_IDLE;
            end
         end
         SMCM_FLOAT: begin
            // Float timer loaded on leaving hold; idle handles the gap
            state_next = SMCM_IDLE;
         end
         default: begin
            state_next = SMCM_IDLE;
            cnt_next   = 6'h00;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // Strobe generation
   // ----------------------------------------------------------------
   wire active    = (state_next == SMCM_SETUP) || (state_next == SMCM_PULSE) ||
                    (state_next == SMCM_READY_WAIT) || (state_next == SMCM_HOLD);
   wire strobing  = (state_next == SMCM_PULSE) || (state_next == SMCM_READY_WAIT);
   wire is_wr     = (state_reg == SMCM_IDLE) ? req_write_i : wr_reg;
   wire [1:0] bsel = (state_reg == SMCM_IDLE) ? req_bytes_i : bytes_reg;
   wire [1:0] lanes = wide ? bsel : 2'h1;
   // Write timed by chip select: select only spans the pulse
   wire cs_on    = (is_wr && wr_by_cs) ? strobing : active;

   always_comb begin
      strb_next         = '1;
      strb_next.cs_n    = ~cs_on;
      if (!byte_kind) begin
         strb_next.rd_n    = ~(strobing & ~is_wr);
         strb_next.wr_n    = ~(strobing & is_wr);
         strb_next.bs_lo_n = ~(active & lanes[0]);
         strb_next.bs_hi_n = ~(active & lanes[1] & wide);
      end else begin
         strb_next.rd_n    = ~(strobing & ~is_wr);
         strb_next.bw_lo_n = ~(strobing & is_wr & lanes[0]);
         strb_next.bw_hi_n = ~(strobing & is_wr & lanes[1]);
      end
   end

   always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         state_reg <= SMCM_IDLE;
         cnt_reg   <= 6'h00;
         wr_reg    <= 1'b0;
         bytes_reg <= 2'h0;
         done_reg  <= 1'b0;
         strb_reg  <= '1;
      end else begin
         state_reg <= state_next;
         cnt_reg   <= cnt_next;
         strb_reg  <= strb_next;
         done_reg  <= (state_reg == SMCM_HOLD) && (state_next != SMCM_HOLD);
         if (state_reg == SMCM_IDLE && state_next == SMCM_SETUP) begin
            wr_reg    <= req_write_i;
            bytes_reg <= req_bytes_i;
         end
      end
   end

   wire unused_ok = in_float;
endmodule // smcm_chip_select

`default_nettype wire

// File: bench/smcm_cs_props.sv
// Port checker for the chip-select sequencer.
// Assumes mode_i and req_write_i hold still while an access runs.
`timescale 1ns/1ps
`default_nettype none
module smcm_cs_props
   import smcm_pkg::*;
(
   input  wire logic          clk_sys_i,
   input  wire logic          sys_rst_i,
   input  wire logic [31:0]   mode_i,
   input  wire logic          req_write_i,
   input  wire logic          req_ready_o,
   input  wire logic          done_o,
   input  wire logic          bus_blocked_o,
   input  wire logic          wide_bus_o,
   input  wire smcm_strobes_t strobes_o
);
   logic [4:0] blk_reg;
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (sys_rst_i);
   // Length of the blocked run, judged when it ends
   always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
      if (sys_rst_i)
         blk_reg <= 5'h00;
      else
         blk_reg <= bus_blocked_o ? blk_reg + 5'h01 : 5'h00;
   end
   width_mirror_a: assert property (wide_bus_o == mode_i[12]) else $error("width");
   narrow_bw_a: assert property (!mode_i[12] |-> strobes_o.bw_lo_n && strobes_o.bw_hi_n)
      else $error("narrow byte write");
   kind0_bw_a: assert property (!mode_i[8] |-> strobes_o.bw_lo_n && strobes_o.bw_hi_n)
      else $error("select kind byte write");
   kind1_plain_a: assert property (mode_i[12] && mode_i[8]
      |-> strobes_o.wr_n && strobes_o.bs_lo_n && strobes_o.bs_hi_n) else $error("kind1");
   read_cs_a: assert property (!strobes_o.rd_n |-> !strobes_o.cs_n) else $error("rd cs");
   blocked_len_a: assert property ($fell(bus_blocked_o)
      |-> blk_reg == {1'h0, mode_i[19:16]} + 5'h01) else $error("blocked length");
   blocked_ready_a: assert property (bus_blocked_o && !mode_i[20] |-> !req_ready_o)
      else $error("ready in float");
   read_blocks_a: assert property (done_o && !req_write_i |-> ##[0:2] bus_blocked_o)
      else $error("read not blocked");
   cover property (done_o && !req_write_i);
   cover property (bus_blocked_o && req_ready_o);
   cover property (!strobes_o.bw_hi_n);
endmodule // smcm_cs_props
bind smcm_chip_select smcm_cs_props i_smcm_cs_props (.clk_sys_i(clk_sys_i),
   .sys_rst_i(sys_rst_i), .mode_i(mode_i), .req_write_i(req_write_i),
   .req_ready_o(req_ready_o), .done_o(done_o), .bus_blocked_o(bus_blocked_o),
   .wide_bus_o(wide_bus_o), .strobes_o(strobes_o));
`default_nettype wire

// File: bench/smcm_ext_dev.sv
// External device model: stalls each strobe pulse by stall_i cycles.
// Assumes active-low strobes from the sequencer.
`timescale 1ns/1ps
`default_nettype none
module smcm_ext_dev
   import smcm_pkg::*;
(
   input  wire logic          clk_sys_i,
   input  wire logic          sys_rst_i,
   input  wire smcm_strobes_t strobes_i,
   input  wire logic [3:0]    stall_i,
   output logic               wait_n_o
);
   logic [3:0] age_reg;
   wire        strb = !(strobes_i.rd_n && strobes_i.wr_n &&
                        strobes_i.bw_lo_n && strobes_i.bw_hi_n);
   always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
      if (sys_rst_i)
         age_reg <= 4'h0;
      else if (!strb)
         age_reg <= 4'h0;
      else if (age_reg != 4'hF)
         age_reg <= age_reg + 4'h1;
   end
   // Pulled up: released whenever no strobe is low
   assign wait_n_o = !(strb && age_reg < stall_i);
endmodule // smcm_ext_dev
`default_nettype wire

// File: bench/smcm_chip_select_tb_top.sv
// Self-checking bench: sequencer plus external device model.
// Assumes package, defines and design files compiled first.
`timescale 1ns/1ps
`default_nettype none
module smcm_chip_select_tb_top
   import smcm_pkg::*;
();
   logic          clk_sys_i, sys_rst_i, req_i, req_write_i, ext_wait_n_i;
   logic          req_ready_o, done_o, bus_blocked_o, wide_bus_o;
   logic [31:0]   mode_i;
   logic [3:0]    stall;
   logic [1:0]    lanes_sel;
   logic [6:0]    seen;
   smcm_timing_t  tim;
   smcm_strobes_t strobes_o;
   int            err_total, checks_done, cs_cnt, base, cyc, n;
   smcm_chip_select i_smcm_chip_select (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
      .mode_i(mode_i), .rd_tim_i(tim), .wr_tim_i(tim), .req_i(req_i),
      .req_write_i(req_write_i), .req_bytes_i(lanes_sel), .ext_wait_n_i(ext_wait_n_i),
      .req_ready_o(req_ready_o), .done_o(done_o), .bus_blocked_o(bus_blocked_o),
      .wide_bus_o(wide_bus_o), .strobes_o(strobes_o));
   smcm_ext_dev i_smcm_ext_dev (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
      .strobes_i(strobes_o), .stall_i(stall), .wait_n_o(ext_wait_n_i));
   initial begin
      clk_sys_i = 1'h0;
      forever #5 clk_sys_i = ~clk_sys_i;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_total++;
         $display("Error at %0t: got %0h want %0h", $time, got, exp);
      end
   endtask
   task automatic print_verdict();
      $display("checks %0d errors %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // Flags: optimize, wide, byte kind, wait mode[1:0], write control
   task automatic setm(input logic [3:0] df, input logic [5:0] f);
      @(posedge clk_sys_i);
      mode_i <= {11'h000, f[5], df, 3'h0, f[4], 3'h0, f[3], 2'h0, f[2:1], 2'h0, f[0], 1'h0};
   endtask
   // Sampled at negedge so each edge's updates have landed
   task automatic acc(input logic wr);
      seen = 7'h7F;
      cs_cnt = 0;
      cyc = 0;
      req_i <= 1'h1;
      req_write_i <= wr;
      do @(negedge clk_sys_i); while (!req_ready_o && ++cyc < 300);
      if (!req_ready_o) begin
         err_total++;
         print_verdict();
      end
      @(posedge clk_sys_i);
      req_i <= 1'h0;
      cyc = 0;
      n = 0;
      do begin
         @(negedge clk_sys_i);
         seen &= strobes_o;
         cs_cnt += !strobes_o.cs_n;
         n += bus_blocked_o;
         cyc++;
      end while (!done_o && cyc < 300);
      if (!done_o) begin
         err_total++;
         print_verdict();
      end
      @(posedge clk_sys_i);
   endtask
   task automatic sc_bytes();
      setm(4'h0, 6'h11);
      acc(1'h1);
      chk(seen, 7'h23);
      chk(wide_bus_o, 1'h1);
      acc(1'h0);
      chk(seen, 7'h13);
      setm(4'h0, 6'h19);
      acc(1'h1);
      chk(seen, 7'h3C);
      acc(1'h0);
      chk(seen, 7'h1F);
      lanes_sel <= 2'h1;
      acc(1'h1);
      chk(seen, 7'h3D);
      lanes_sel <= 2'h3;
      setm(4'h0, 6'h01);
      acc(1'h1);
      chk(seen, 7'h27);
      chk(wide_bus_o, 1'h0);
      setm(4'h0, 6'h09);
      acc(1'h1);
      chk(seen, 7'h27);
   endtask
   task automatic sc_float(input logic [3:0] df, input logic opt);
      setm(df, {opt, 5'h11});
      acc(1'h0);
      cyc = 0;
      repeat (40) begin
         @(negedge clk_sys_i);
         n += bus_blocked_o;
         cyc += bus_blocked_o && req_ready_o;
      end
      chk(n, df + 1);
      chk(cyc != 0, opt);
   endtask
   task automatic sc_wait();
      setm(4'h0, 6'h11);
      acc(1'h1);
      base = cyc;
      stall <= 4'h8;
      for (int m = 0; m < 4; m++) begin
         setm(4'h0, {3'h2, m[1:0], 1'h1});
         acc(1'h1);
         chk(cyc > base, m > 1);
      end
      setm(4'h0, 6'h10);
      acc(1'h1);
      chk(cs_cnt, tim.pulse + 1);
   endtask
   initial begin
      err_total = 0;
      checks_done = 0;
      sys_rst_i = 1'h1;
      req_i = 1'h0;
      req_write_i = 1'h0;
      mode_i = 32'h0000_0000;
      stall = 4'h0;
      lanes_sel = 2'h3;
      tim = '{6'h10, 6'h04, 6'h01};
      repeat (20) @(posedge clk_sys_i);
      sys_rst_i <= 1'h0;
      sc_bytes();
      sc_float(4'h0, 1'h0);
      sc_float(4'hF, 1'h0);
      sc_float(4'hF, 1'h1);
      sc_wait();
      print_verdict();
   end
endmodule // smcm_chip_select_tb_top
`default_nettype wire
